// File: hdl/ccm_pkg.sv
// Package of register map, field layout and mode types for the compare/capture module
`default_nettype none
package ccm_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [7:0] CCM_MODE_ADDR = 8'h00;
  localparam logic [7:0] CCM_CMPL_ADDR = 8'h04;
  localparam logic [7:0] CCM_CMPH_ADDR = 8'h08;
  localparam logic [7:0] CCM_STAT_ADDR = 8'h0C;
  localparam logic [7:0] CCM_WDOG_ADDR = 8'h10;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CCM_RSVD_BIT = 7;
  localparam int CCM_STAT_FLAG_BIT = 0;
  localparam int CCM_STAT_PIN_BIT = 1;
  localparam int CCM_STAT_OUT_BIT = 2;
  // Watchdog arm bit sits where the counter mode register keeps it (value 40H)
  localparam int CCM_WD_ARM_BIT = 6;

  // ************************************************************
  // Reset values and PWM wrap points
  // ************************************************************
  localparam logic [7:0] CCM_MODE_RST = 8'h00;
  localparam logic [7:0] CCM_CMP_RST = 8'h00;
  localparam logic CCM_PIN_OUT_RST = 1'b1;
  localparam logic [7:0] CCM_PWM_WRAP_FROM = 8'hFF;
  localparam logic [7:0] CCM_PWM_WRAP_TO = 8'h00;

  // Module mode control, bit 7 down to bit 0
  typedef struct packed {
    logic rsvd;
    logic comparator_enable;
    logic rising_edge_capture_enable;
    logic falling_edge_capture_enable;
    logic match_flag_enable;
    logic match_toggle_enable;
    logic pulse_width_mode_enable;
    logic module_interrupt_enable;
  } ccm_mode_s;

  // Decoded function of the module
  typedef enum logic [2:0] {
    CCM_FN_IDLE,
    CCM_FN_CAPTURE,
    CCM_FN_TIMER,
    CCM_FN_HSO,
    CCM_FN_PWM
  } ccm_fn_e;

endpackage
`default_nettype wire

// File: hdl/ccm_module.sv
// Compare/capture module of a programmable counter array, with APB registers
// Contract
// - Mode bit 6 enables the comparator; compare modes idle while it is zero.
// - Mode bit 5 enables counter capture on a rising pin edge.
// - Mode bit 4 enables counter capture on a falling pin edge.
// - Both capture enables set gives a 16-bit capture on either edge.
// - A valid edge copies the counter into the capture bytes and sets the flag.
// - Match bit 3 makes counter equality with compare set the event flag.
// - Toggle bit 2 makes counter equality with compare invert the pin.
// - Interrupt request only while event flag and interrupt enable bit 0 are one.
// - Mode bit 7 is reserved and has no function.
// - Comparator plus match alone forms a 16-bit software timer.
// - Comparator, match and toggle form a high-speed output toggling on equality.
// - Bit 1 with comparator enable makes the pin an 8-bit PWM output.
// - PWM pin low while counter low byte below compare low, else high.
// - On low byte wrap FF to 00 the active duty reloads from high byte.
// - PWM frequency comes from the shared counter; duty is per module.
// - Only module 4 offers the watchdog, and only with comparator and match on and PWM off.
// - Armed watchdog match raises an internal reset, not the external pin.
// - Arming needs module 4 in compare mode plus the watchdog arm bit.
// - Clearing the arm bit before a match prevents the watchdog reset.
`default_nettype none
module ccm_module
  import ccm_pkg::*;
#(
  parameter int MODULE_INDEX = 4
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared counter
  input wire logic [15:0] count_value,
  input wire logic count_tick,
  // External pin
  input wire logic module_io_pin_in,
  output logic module_io_pin_out,
  output logic module_io_pin_oe,
  // Events
  output logic irq,
  output logic wd_reset
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic setup_phase;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  ccm_mode_s mode_q;
  logic [7:0] compare_low_q;
  logic [7:0] compare_high_q;
  logic flag_q;
  logic pin_out_q;
  logic pin_oe_q;
  logic irq_q;
  logic wd_reset_q;
  logic watchdog_arm_bit_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic [7:0] prev_low_q;

  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
  assign addr_ok = (paddr == CCM_MODE_ADDR) || (paddr == CCM_CMPL_ADDR) ||
                   (paddr == CCM_CMPH_ADDR) || (paddr == CCM_STAT_ADDR) ||
                   (paddr == CCM_WDOG_ADDR);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      CCM_MODE_ADDR: rd_mux[7:0] = {1'b0, mode_q[6:0]};
      CCM_CMPL_ADDR: rd_mux[7:0] = compare_low_q;
      CCM_CMPH_ADDR: rd_mux[7:0] = compare_high_q;
      CCM_STAT_ADDR:
      begin
        rd_mux[CCM_STAT_FLAG_BIT] = flag_q;
        rd_mux[CCM_STAT_PIN_BIT] = pin_s2_q;
        rd_mux[CCM_STAT_OUT_BIT] = pin_out_q;
      end
      CCM_WDOG_ADDR: rd_mux[CCM_WD_ARM_BIT] = watchdog_arm_bit_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero wait states: ready is raised for the first access cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup_phase;
      pslverr_q <= setup_phase && !addr_ok;
      if (setup_phase)
      begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  logic cmp_on;
  logic pwm_on;
  logic cap_on;
  logic eq16;
  logic match_evt;
  logic rise_evt;
  logic fall_evt;
  logic cap_evt;
  logic wrap_evt;
  logic wd_capable;
  logic wd_armed;

  assign cmp_on = mode_q.comparator_enable;
  assign pwm_on = cmp_on && mode_q.pulse_width_mode_enable;
  assign cap_on = !mode_q.match_flag_enable && !mode_q.match_toggle_enable &&
                  !mode_q.pulse_width_mode_enable;
  assign eq16 = count_value == {compare_high_q, compare_low_q};
  // Equality counts only when the shared counter has just stepped
  assign match_evt = count_tick && eq16 && cmp_on && !pwm_on;
  // Edges from the second and third stage only; stage one stays private
  assign rise_evt = pin_s2_q && !pin_s3_q;
  assign fall_evt = !pin_s2_q && pin_s3_q;
  assign cap_evt = cap_on && ((rise_evt && mode_q.rising_edge_capture_enable) ||
                              (fall_evt && mode_q.falling_edge_capture_enable));
  assign wrap_evt = count_tick && (prev_low_q == CCM_PWM_WRAP_FROM) &&
                    (count_value[7:0] == CCM_PWM_WRAP_TO);
  assign wd_capable = MODULE_INDEX == 4;
  assign wd_armed = wd_capable && watchdog_arm_bit_q && cmp_on &&
                    mode_q.match_flag_enable && !mode_q.pulse_width_mode_enable;

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= module_io_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      prev_low_q <= CCM_CMP_RST;
    end
    else if (count_tick)
    begin
      prev_low_q <= count_value[7:0];
    end
  end

  // ************************************************************
  // Registers written by software
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mode_q <= CCM_MODE_RST;
      watchdog_arm_bit_q <= 1'b0;
    end
    else if (wr_en)
    begin
      if (paddr == CCM_MODE_ADDR)
      begin
        mode_q <= {1'b0, pwdata[6:0]};
      end
      if (paddr == CCM_WDOG_ADDR)
      begin
        watchdog_arm_bit_q <= pwdata[CCM_WD_ARM_BIT];
      end
    end
  end

  // Hardware loads win over a bus write in the same cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      compare_low_q <= CCM_CMP_RST;
      compare_high_q <= CCM_CMP_RST;
    end
    else
    begin
      if (wr_en && paddr == CCM_CMPL_ADDR)
      begin
        compare_low_q <= pwdata[7:0];
      end
      if (wr_en && paddr == CCM_CMPH_ADDR)
      begin
        compare_high_q <= pwdata[7:0];
      end
      if (cap_evt)
      begin
        compare_low_q <= count_value[7:0];
        compare_high_q <= count_value[15:8];
      end
      if (pwm_on && wrap_evt)
      begin
        compare_low_q <= compare_high_q;
      end
    end
  end

  // ************************************************************
  // Event flag and interrupt
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      flag_q <= 1'b0;
    end
    else if (cap_evt || (match_evt && mode_q.match_flag_enable))
    begin
      flag_q <= 1'b1;
    end
    else if (wr_en && paddr == CCM_STAT_ADDR && pwdata[CCM_STAT_FLAG_BIT])
    begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= flag_q && mode_q.module_interrupt_enable;
    end
  end

  // ************************************************************
  // Pin output: toggle and PWM
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin_out_q <= CCM_PIN_OUT_RST;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      pin_oe_q <= pwm_on || (cmp_on && mode_q.match_toggle_enable);
      if (pwm_on && count_tick)
      begin
        // Shared counter sets the period; this module's byte sets the duty
        pin_out_q <= count_value[7:0] >= compare_low_q;
      end
      else if (match_evt && mode_q.match_toggle_enable)
      begin
        pin_out_q <= !pin_out_q;
      end
    end
  end

  // ************************************************************
  // Watchdog
  // ************************************************************
  // Reset request is an internal one-cycle pulse; no pin is driven
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wd_reset_q <= 1'b0;
    end
    else
    begin
      wd_reset_q <= wd_armed && match_evt;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign module_io_pin_out = pin_out_q;
  assign module_io_pin_oe = pin_oe_q;
  assign irq = irq_q;
  assign wd_reset = wd_reset_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  mode_rsvd_a: assert property (setup_phase && !pwrite && paddr == CCM_MODE_ADDR
    |=> prdata[CCM_RSVD_BIT] == 1'b0)
    else $error("reserved mode bit read back non-zero");

  rise_capture_a: assert property (cap_on && mode_q.rising_edge_capture_enable
    && rise_evt |=> {compare_high_q, compare_low_q} == $past(count_value) && flag_q)
    else $error("rising edge did not capture the counter");

  fall_capture_a: assert property (cap_on && mode_q.falling_edge_capture_enable
    && fall_evt |=> {compare_high_q, compare_low_q} == $past(count_value) && flag_q)
    else $error("falling edge did not capture the counter");

  edge_sync_a: assert property ($rose(pin_s2_q) && cap_on
    && mode_q.rising_edge_capture_enable |-> !pin_s3_q && cap_evt)
    else $error("edge not taken from successive synchronised samples");

  timer_flag_a: assert property (match_evt && mode_q.match_flag_enable
    |=> flag_q ##1 flag_q || $past(wr_en))
    else $error("match did not set the event flag");

  hso_toggle_a: assert property (match_evt && mode_q.match_toggle_enable
    |=> pin_out_q != $past(pin_out_q))
    else $error("high-speed output did not toggle on match");

  irq_gate_a: assert property (irq_q |-> $past(flag_q)
    && $past(mode_q.module_interrupt_enable))
    else $error("interrupt raised without flag and enable");

  pwm_level_a: assert property (pwm_on && count_tick
    |=> pin_out_q == ($past(count_value[7:0]) >= $past(compare_low_q)))
    else $error("PWM level wrong for counter low byte");

  pwm_reload_a: assert property (pwm_on && wrap_evt
    |=> compare_low_q == $past(compare_high_q))
    else $error("PWM duty not reloaded on wrap");

  idle_quiet_a: assert property (mode_q == CCM_MODE_RST && !wr_en
    |=> $stable(pin_out_q) && !$rose(flag_q))
    else $error("idle module changed pin or flag");

  cmp_off_a: assert property (!cmp_on |=> !wd_reset_q)
    else $error("comparator off yet match acted");

  wd_fire_a: assert property (wd_armed && match_evt |=> wd_reset_q ##1 !wd_reset_q
    || $past(wd_armed && match_evt))
    else $error("armed watchdog match gave no single reset pulse");

  wd_disarm_a: assert property (!watchdog_arm_bit_q |=> !wd_reset_q)
    else $error("watchdog reset while disarmed");

endmodule
`default_nettype wire

// File: tb/ccm_pin_model.sv
// Far-side model of the module's external capture/compare pin
`default_nettype none
module ccm_pin_model
(
  // Far-side drive
  input wire logic far_level,
  // Module side
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // The module owns the wire while it drives; the far side drives it otherwise
  assign pin_level = pin_oe ? pin_out : far_level;
endmodule
`default_nettype wire

// File: tb/pca_compare_capture_module_tb.sv
// Self-checking testbench of the compare/capture module
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module pca_compare_capture_module_tb
  import ccm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, srst, psel, penable, pwrite, count_tick, pin_drive, pin_level;
  logic pready, pslverr, pin_out, pin_oe, irq, wd_reset, e, wd_s, pin_s, hit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] count_value, exp_c, v;
  logic [7:0] modes [4] = '{8'h00, 8'h20, 8'h10, 8'h30};
  logic [15:0] pv [6] = '{16'h007F, 16'h0080, 16'h00FF, 16'h0100, 16'h0140, 16'h013F};
  logic pe [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic wd_other, wd_o;
  int err_total, comparisons;

  ccm_module i_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_value(count_value), .count_tick(count_tick),
    .module_io_pin_in(pin_level), .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe),
    .irq(irq), .wd_reset(wd_reset));
  ccm_pin_model i_pin (.far_level(pin_drive), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level));
  // A module other than number 4 must never raise the watchdog reset
  ccm_module #(.MODULE_INDEX(0)) i_dut_other (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .count_value(count_value), .count_tick(count_tick),
    .module_io_pin_in(pin_level), .module_io_pin_out(), .module_io_pin_oe(), .irq(),
    .wd_reset(wd_other));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // APB master and counter drivers
  // ************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      `CHK(1'b0, 1'b1, "no pready")
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 8'h00);
    `CHK(r, x, m)
  endtask

  task automatic flagc(input logic x, input string m);
    apb(1'b0, CCM_STAT_ADDR, 8'h00);
    `CHK(r[CCM_STAT_FLAG_BIT], x, m)
  endtask

  // Outputs are sampled just after the edge that takes the tick
  task automatic tick(input logic [15:0] t);
    @(posedge clock);
    count_value <= t;
    count_tick <= 1'b1;
    @(posedge clock);
    count_tick <= 1'b0;
    #1;
    wd_s = wd_reset;
    pin_s = pin_out;
    wd_o = wd_other;
  endtask

  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    count_value = 16'h0000;
    count_tick = 1'b0;
    pin_drive = 1'b0;
    err_total = 0;
    comparisons = 0;
    exp_c = {CCM_CMP_RST, CCM_CMP_RST};
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rdc(CCM_MODE_ADDR, {24'h0, CCM_MODE_RST}, "mode reset");
    rdc(CCM_CMPL_ADDR, {24'h0, CCM_CMP_RST}, "low reset");
    rdc(CCM_CMPH_ADDR, {24'h0, CCM_CMP_RST}, "high reset");
    rdc(CCM_STAT_ADDR, {29'h0, CCM_PIN_OUT_RST, 2'b00}, "status reset");
    rdc(CCM_WDOG_ADDR, 32'h0, "watchdog reset");
    `CHK(pin_oe, 1'b0, "oe reset")
    rdc(8'h14, 32'h0, "unmapped data");
    `CHK(e, 1'b1, "unmapped error")
    wr(CCM_MODE_ADDR, 8'h80);
    rdc(CCM_MODE_ADDR, 32'h0, "reserved bit");
    $display("test reset done");
    // Each mode sees one rising and one falling edge, counter held meanwhile
    for (int i = 0; i < 4; i++)
    begin
      wr(CCM_MODE_ADDR, modes[i]);
      for (int j = 0; j < 2; j++)
      begin
        v = {modes[i], 7'h08, j[0]};
        hit = (j == 0) ? modes[i][5] : modes[i][4];
        @(posedge clock);
        count_value <= v;
        pin_drive <= (j == 0);
        repeat (6) @(posedge clock);
        if (hit)
          exp_c = v;
        rdc(CCM_CMPL_ADDR, {24'h0, exp_c[7:0]}, "capture low");
        rdc(CCM_CMPH_ADDR, {24'h0, exp_c[15:8]}, "capture high");
        flagc(hit, "capture flag");
        wr(CCM_STAT_ADDR, 8'h01);
      end
    end
    $display("test capture done");
    wr(CCM_MODE_ADDR, 8'h09);
    wr(CCM_CMPL_ADDR, 8'h00);
    wr(CCM_CMPH_ADDR, 8'h01);
    tick(16'h0100);
    flagc(1'b0, "comparator off");
    wr(CCM_MODE_ADDR, 8'h49);
    tick(16'h0101);
    flagc(1'b0, "timer no match");
    tick(16'h0100);
    flagc(1'b1, "timer match");
    `CHK(irq, 1'b1, "irq on")
    wr(CCM_MODE_ADDR, 8'h48);
    repeat (2) @(posedge clock);
    #1;
    `CHK(irq, 1'b0, "irq masked")
    wr(CCM_STAT_ADDR, 8'h01);
    flagc(1'b0, "flag cleared");
    $display("test timer done");
    wr(CCM_MODE_ADDR, 8'h4C);
    tick(16'h0100);
    `CHK(pin_s, 1'b0, "toggle one")
    `CHK(pin_oe, 1'b1, "toggle drives")
    tick(16'h0101);
    `CHK(pin_s, 1'b0, "no toggle")
    tick(16'h0100);
    `CHK(pin_s, 1'b1, "toggle two")
    wr(CCM_STAT_ADDR, 8'h01);
    $display("test toggle done");
    wr(CCM_MODE_ADDR, 8'h42);
    wr(CCM_CMPL_ADDR, 8'h80);
    wr(CCM_CMPH_ADDR, 8'h40);
    for (int k = 0; k < 6; k++)
    begin
      tick(pv[k]);
      `CHK(pin_s, pe[k], "pwm level")
    end
    rdc(CCM_CMPL_ADDR, 32'h40, "duty reload");
    flagc(1'b0, "pwm no flag");
    $display("test pwm done");
    wr(CCM_MODE_ADDR, 8'h48);
    wr(CCM_WDOG_ADDR, 8'h40);
    rdc(CCM_WDOG_ADDR, 32'h40, "arm readback");
    wr(CCM_CMPL_ADDR, 8'h00);
    wr(CCM_CMPH_ADDR, 8'h02);
    tick(16'h0200);
    `CHK(wd_s, 1'b1, "watchdog fires")
    `CHK(wd_o, 1'b0, "watchdog module 4 only")
    @(posedge clock);
    #1;
    `CHK(wd_reset, 1'b0, "watchdog pulse")
    wr(CCM_WDOG_ADDR, 8'h00);
    tick(16'h0200);
    `CHK(wd_s, 1'b0, "watchdog disarmed")
    // Rearmed, with the compare value moved ahead of the counter
    wr(CCM_WDOG_ADDR, 8'h40);
    wr(CCM_CMPL_ADDR, 8'h00);
    wr(CCM_CMPH_ADDR, 8'h03);
    tick(16'h0200);
    `CHK(wd_s, 1'b0, "compare moved ahead")
    tick(16'h0300);
    `CHK(wd_s, 1'b1, "moved compare fires")
    $display("test watchdog done");
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
